// ---- rtl/cmh_pkg.sv ----
// Functional notes
// - Upstream octets go out LSB first
// - Multi-octet numbers sent MSB octet first
// - Signed values use two's complement
// - Tuple type/length one byte; lengths nonzero
// - Control byte, parameter, length, extension, check
// - Length equals extension plus post-check bytes
// - Check sequence CRC-CCITT over control through extension
// - Top two control bits give frame type
// - Five parameter bits, LSB is extension flag
// - With extension, parameter byte holds 0..240 length
// - Without extension, parameter is count or reserved
// - 0xff is stuffing, never a header start
// - Physical side marks each upstream frame start
// - Downstream exchange is one octet at a time
// - MAC-specific kinds: timing, management, request, fragment, concat
// - Service identifier is 14 low bits
package cmh_pkg;

	// ----------------------------------------
	// Register map (APB, one word each)
	// ----------------------------------------
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  OFF_CTRL    = 8'h00;
	localparam logic [7:0]  OFF_HDR     = 8'h04;
	localparam logic [7:0]  OFF_DATA    = 8'h08;
	localparam logic [7:0]  OFF_STATUS  = 8'h0c;
	localparam logic [7:0]  OFF_HCS     = 8'h10;

	localparam int unsigned CTRL_GO_BIT      = 0;
	localparam int unsigned CTRL_PATH_BIT    = 1;
	localparam int unsigned HDR_FC_LSB       = 0;
	localparam int unsigned HDR_PARM_LSB     = 8;
	localparam int unsigned HDR_LEN_LSB      = 16;
	localparam int unsigned STAT_BUSY_BIT    = 0;
	localparam int unsigned STAT_REFUSED_BIT = 1;
	localparam int unsigned STAT_WHY_LSB     = 2;
	localparam int unsigned STAT_PATH_BIT    = 4;
	localparam int unsigned STAT_COUNT_LSB   = 16;

	// Refusal reasons
	localparam logic [1:0] WHY_STUFF   = 2'h0;
	localparam logic [1:0] WHY_EXT     = 2'h1;
	localparam logic [1:0] WHY_LENGTH  = 2'h2;
	localparam logic [1:0] WHY_SID     = 2'h3;

	// ----------------------------------------
	// Frame control byte layout
	// ----------------------------------------
	localparam int unsigned FRAME_TYPE_FIELD_MSB = 7;
	localparam int unsigned FRAME_TYPE_FIELD_LSB = 6;
	localparam int unsigned TYPE_PARAMETER_FIELD_MSB = 5;
	localparam int unsigned TYPE_PARAMETER_FIELD_LSB = 1;
	localparam int unsigned FC_EXT_BIT  = 0;

	localparam logic [1:0] FT_PACKET   = 2'h0;
	localparam logic [1:0] FT_ATM      = 2'h1;
	localparam logic [1:0] FT_RESERVED = 2'h2;
	localparam logic [1:0] FT_MAC      = 2'h3;

	localparam logic [4:0] KIND_TIMING  = 5'h00;
	localparam logic [4:0] KIND_MGMT    = 5'h01;
	localparam logic [4:0] KIND_REQUEST = 5'h02;
	localparam logic [4:0] KIND_FRAG    = 5'h03;
	localparam logic [4:0] KIND_CONCAT  = 5'h1c;

	// ----------------------------------------
	// Sizes and coding
	// ----------------------------------------
	localparam logic [7:0]  STUFF_BYTE = 8'hff;
	localparam logic [7:0]  EXT_MAX    = 8'hf0;
	localparam logic [8:0]  HDR_FIXED  = 9'h004;
	localparam logic [8:0]  HDR_TOTAL  = 9'h006;
	localparam int unsigned BUF_DEPTH  = 256;
	localparam int unsigned SID_W      = 14;
	localparam logic [15:0] HCS_POLY   = 16'h1021;
	localparam logic [15:0] HCS_INIT   = 16'hffff;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} cmh_state_e;

endpackage

// ---- rtl/cmh_crc16.sv ----
module cmh_crc16 (
	input  wire logic [15:0] crc_in,
	input  wire logic [7:0]  data_in,
	output logic      [15:0] crc_out
);

	always_comb begin
		logic [15:0] c;
		c = crc_in;
		for (int i = 7; i >= 0; i--) begin
			if (c[15] ^ data_in[i]) begin
				c = {c[14:0], 1'b0} ^ cmh_pkg::HCS_POLY;
			end else begin
				c = {c[14:0], 1'b0};
			end
		end
		crc_out = c;
	end

endmodule

// ---- rtl/cmh_host.sv ----
module cmh_host (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             us_bit,
	output logic             us_valid,
	output logic             us_frame_start,
	output logic      [7:0]  ds_octet,
	output logic             ds_valid
);

	typedef struct packed {
		cmh_pkg::cmh_state_e st;
		logic                path;
		logic [7:0]          fc;
		logic [7:0]          parm;
		logic [15:0]         len;
		logic [8:0]          wcnt;
		logic [8:0]          pos;
		logic [8:0]          opos;
		logic [8:0]          total;
		logic [2:0]          bitn;
		logic [7:0]          shreg;
		logic [15:0]         crc;
		logic [15:0]         header_check_sequence;
		logic                refused;
		logic [1:0]          why;
		logic                us_bit;
		logic                us_valid;
		logic                us_start;
		logic [7:0]          ds_octet;
		logic                ds_valid;
		logic [31:0]         prdata;
		logic                pready;
		logic                pslverr;
	} cmh_host_s;

	cmh_host_s   r_reg;
	cmh_host_s   r_next;
	logic [7:0]  mem [cmh_pkg::BUF_DEPTH];
	logic        wr_data;
	logic [7:0]  tx_byte;
	logic [15:0] crc_step;
	logic [8:0]  ext_n;
	logic [8:0]  hdr_end;

	// ----------------------------------------
	// Header decoding
	// ----------------------------------------
	function automatic logic [1:0] frame_type(input logic [7:0] fc);
		frame_type = fc[cmh_pkg::FRAME_TYPE_FIELD_MSB:cmh_pkg::FRAME_TYPE_FIELD_LSB];
	endfunction

	function automatic logic is_mac_kind(input logic [7:0] fc, input logic [4:0] kind);
		is_mac_kind = (frame_type(fc) == cmh_pkg::FT_MAC) &&
			(fc[cmh_pkg::TYPE_PARAMETER_FIELD_MSB:cmh_pkg::TYPE_PARAMETER_FIELD_LSB] == kind);
	endfunction

	function automatic logic [7:0] parm_on_wire(input logic [7:0] fc, input logic [7:0] parm);
		// Reserved use goes out as zero
		if (fc[cmh_pkg::FC_EXT_BIT] || is_mac_kind(fc, cmh_pkg::KIND_CONCAT) ||
			is_mac_kind(fc, cmh_pkg::KIND_REQUEST)) begin
			parm_on_wire = parm;
		end else begin
			parm_on_wire = 8'h00;
		end
	endfunction

	assign ext_n   = r_reg.fc[cmh_pkg::FC_EXT_BIT] ? {1'b0, r_reg.parm} : 9'h000;
	assign hdr_end = cmh_pkg::HDR_FIXED + ext_n;

	// ----------------------------------------
	// Byte selection, fixed order on the line
	// ----------------------------------------
	always_comb begin
		if (r_reg.pos == 9'h000) begin
			tx_byte = r_reg.fc;
		end else if (r_reg.pos == 9'h001) begin
			tx_byte = parm_on_wire(r_reg.fc, r_reg.parm);
		end else if (r_reg.pos == 9'h002) begin
			tx_byte = r_reg.len[15:8];
		end else if (r_reg.pos == 9'h003) begin
			tx_byte = r_reg.len[7:0];
		end else if (r_reg.pos < hdr_end) begin
			tx_byte = mem[8'(r_reg.pos - cmh_pkg::HDR_FIXED)];
		end else if (r_reg.pos == hdr_end) begin
			tx_byte = r_reg.crc[15:8];
		end else if (r_reg.pos == hdr_end + 9'h001) begin
			tx_byte = r_reg.header_check_sequence[7:0];
		end else begin
			tx_byte = mem[8'(r_reg.pos - cmh_pkg::HDR_TOTAL)];
		end
	end

	cmh_crc16 u_crc (
		.crc_in  (r_reg.crc),
		.data_in (tx_byte),
		.crc_out (crc_step)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic        acc;
		logic        setup;
		logic        busy;
		logic        go;
		logic        ext;
		logic        is_req;
		logic signed [9:0] payload;
		acc     = psel && penable && r_reg.pready;
		setup   = psel && !penable;
		busy    = (r_reg.st == cmh_pkg::ST_SEND);
		go      = 1'b0;
		ext     = r_reg.fc[cmh_pkg::FC_EXT_BIT];
		is_req  = is_mac_kind(r_reg.fc, cmh_pkg::KIND_REQUEST);
		payload = $signed({1'b0, r_reg.wcnt}) - $signed({1'b0, ext_n});
		r_next  = r_reg;
		wr_data = 1'b0;

		// Bus slave: zero wait states, answer in first access cycle
		r_next.pready = setup;
		if (setup) begin
			r_next.pslverr = 1'b0;
			r_next.prdata  = 32'h0000_0000;
			case (paddr)
				cmh_pkg::OFF_CTRL: begin
					r_next.prdata[cmh_pkg::CTRL_PATH_BIT] = r_reg.path;
					r_next.pslverr = pwrite && busy;
				end
				cmh_pkg::OFF_HDR: begin
					r_next.prdata  = {r_reg.len, r_reg.parm, r_reg.fc};
					r_next.pslverr = pwrite && busy;
				end
				cmh_pkg::OFF_DATA: begin
					r_next.pslverr = pwrite && (busy || r_reg.wcnt[8]);
				end
				cmh_pkg::OFF_STATUS: begin
					r_next.prdata[cmh_pkg::STAT_BUSY_BIT]    = busy;
					r_next.prdata[cmh_pkg::STAT_REFUSED_BIT] = r_reg.refused;
					r_next.prdata[cmh_pkg::STAT_WHY_LSB +: 2] = r_reg.why;
					r_next.prdata[cmh_pkg::STAT_PATH_BIT]    = r_reg.path;
					r_next.prdata[cmh_pkg::STAT_COUNT_LSB +: 9] = r_reg.wcnt;
				end
				cmh_pkg::OFF_HCS: begin
					r_next.prdata[15:0] = r_reg.header_check_sequence;
				end
				default: begin
					r_next.pslverr = 1'b1;
				end
			endcase
		end

		if (acc && pwrite && !r_reg.pslverr) begin
			case (paddr)
				cmh_pkg::OFF_CTRL: begin
					r_next.path = pwdata[cmh_pkg::CTRL_PATH_BIT];
					go = pwdata[cmh_pkg::CTRL_GO_BIT];
				end
				cmh_pkg::OFF_HDR: begin
					r_next.fc   = pwdata[cmh_pkg::HDR_FC_LSB +: 8];
					r_next.parm = pwdata[cmh_pkg::HDR_PARM_LSB +: 8];
					r_next.len  = pwdata[cmh_pkg::HDR_LEN_LSB +: 16];
				end
				cmh_pkg::OFF_DATA: begin
					wr_data     = 1'b1;
					r_next.wcnt = r_reg.wcnt + 9'h001;
				end
				cmh_pkg::OFF_STATUS: begin
					if (pwdata[cmh_pkg::STAT_REFUSED_BIT]) begin
						r_next.refused = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Launch checks; a refusal set wins over a clear in the same cycle
		if (go) begin
			if (r_reg.fc == cmh_pkg::STUFF_BYTE) begin
				r_next.refused = 1'b1;
				r_next.why     = cmh_pkg::WHY_STUFF;
			end else if (ext && ((r_reg.parm > cmh_pkg::EXT_MAX) || (payload < 0))) begin
				r_next.refused = 1'b1;
				r_next.why     = cmh_pkg::WHY_EXT;
			end else if (is_req && (r_reg.len[15:cmh_pkg::SID_W] != 2'h0)) begin
				r_next.refused = 1'b1;
				r_next.why     = cmh_pkg::WHY_SID;
			end else if ((is_req && payload != 0) || (!is_req && {7'h00, r_reg.wcnt} != r_reg.len)) begin
				r_next.refused = 1'b1;
				r_next.why     = cmh_pkg::WHY_LENGTH;
			end else begin
				// Zero-length extension is legal here
				r_next.st    = cmh_pkg::ST_SEND;
				r_next.pos   = 9'h000;
				r_next.bitn  = 3'h0;
				r_next.crc   = cmh_pkg::HCS_INIT;
				r_next.total = cmh_pkg::HDR_TOTAL + r_reg.wcnt;
			end
		end

		// Line side
		r_next.us_valid = 1'b0;
		r_next.us_start = 1'b0;
		r_next.us_bit   = 1'b0;
		r_next.ds_valid = 1'b0;
		r_next.ds_octet = cmh_pkg::STUFF_BYTE;
		if (busy) begin
			if (r_reg.bitn != 3'h0) begin
				r_next.us_valid = 1'b1;
				r_next.us_bit   = r_reg.shreg[0];
				r_next.shreg    = {1'b0, r_reg.shreg[7:1]};
				r_next.bitn     = r_reg.bitn + 3'h1;
			end else if (r_reg.pos == r_reg.total) begin
				r_next.st   = cmh_pkg::ST_IDLE;
				r_next.wcnt = 9'h000;
			end else begin
				r_next.pos  = r_reg.pos + 9'h001;
				r_next.opos = r_reg.pos;
				if (r_reg.pos < hdr_end) begin
					r_next.crc = crc_step;
				end
				if (r_reg.pos == hdr_end) begin
					r_next.header_check_sequence = r_reg.crc;
				end
				if (r_reg.path) begin
					r_next.ds_valid = 1'b1;
					r_next.ds_octet = tx_byte;
				end else begin
					r_next.us_valid = 1'b1;
					r_next.us_bit   = tx_byte[0];
					r_next.shreg    = {1'b0, tx_byte[7:1]};
					r_next.bitn     = 3'h1;
					r_next.us_start = (r_reg.pos == 9'h000);
				end
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Buffer holds extension then payload; no reset, contents gated by wcnt
	always_ff @(posedge clk) begin
		if (wr_data) begin
			mem[r_reg.wcnt[7:0]] <= pwdata[7:0];
		end
	end

	assign prdata         = r_reg.prdata;
	assign pready         = r_reg.pready;
	assign pslverr        = r_reg.pslverr;
	assign us_bit         = r_reg.us_bit;
	assign us_valid       = r_reg.us_valid;
	assign us_frame_start = r_reg.us_start;
	assign ds_octet       = r_reg.ds_octet;
	assign ds_valid       = r_reg.ds_valid;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	a_serial_lsb_first: assert property (
		us_frame_start |-> (us_bit == r_reg.fc[0]) ##1 (us_bit == r_reg.fc[1]) ##6 (us_bit == r_reg.fc[7]))
		else $error("serial control byte not LSB first");

	a_start_with_bits: assert property (
		us_frame_start |-> us_valid [*8] ##1 !us_frame_start)
		else $error("frame start not followed by a full octet");

	a_len_msb_first: assert property (
		(ds_valid && r_reg.opos == 9'h002) |-> ds_octet == r_reg.len[15:8] ##1 ds_octet == r_reg.len[7:0])
		else $error("length not sent high octet first");

	a_fc_leads_frame: assert property (
		(ds_valid && !$past(ds_valid)) |-> ds_octet == r_reg.fc && r_reg.opos == 9'h000)
		else $error("frame does not open with control byte");

	a_no_stuff_start: assert property (
		$rose(ds_valid) |-> ds_octet != cmh_pkg::STUFF_BYTE)
		else $error("stuff byte used as header start");

	a_hcs_on_wire: assert property (
		(ds_valid && r_reg.opos == hdr_end) |-> ds_octet == r_reg.header_check_sequence[15:8]
			##1 (ds_valid && ds_octet == r_reg.header_check_sequence[7:0]))
		else $error("check sequence misplaced");

	a_one_path_only: assert property (
		ds_valid |-> !us_valid && r_reg.path)
		else $error("octet path active with serial path");

	a_launch_legal: assert property (
		$rose(r_reg.st == cmh_pkg::ST_SEND) |-> !(r_reg.fc[cmh_pkg::FC_EXT_BIT] && r_reg.parm > cmh_pkg::EXT_MAX)
			&& r_reg.total == cmh_pkg::HDR_TOTAL + r_reg.wcnt)
		else $error("illegal header launched");

	a_length_matches: assert property (
		($rose(r_reg.st == cmh_pkg::ST_SEND) && !is_mac_kind(r_reg.fc, cmh_pkg::KIND_REQUEST))
			|-> r_reg.len == {7'h00, r_reg.wcnt})
		else $error("length field mismatch at launch");

	a_sid_width: assert property (
		($rose(r_reg.st == cmh_pkg::ST_SEND) && is_mac_kind(r_reg.fc, cmh_pkg::KIND_REQUEST))
			|-> r_reg.len[15:cmh_pkg::SID_W] == 2'h0)
		else $error("service identifier wider than 14 bits");

	a_apb_one_beat: assert property (
		pready |=> !pready)
		else $error("ready held more than one cycle");

	c_serial_frame: cover property (us_frame_start);
	c_octet_frame:  cover property ($rose(ds_valid));
	c_refused:      cover property ($rose(r_reg.refused));
	c_ext_header:   cover property ($rose(r_reg.st == cmh_pkg::ST_SEND) && r_reg.fc[cmh_pkg::FC_EXT_BIT]);

endmodule

// ---- bench/cmh_phy_model.sv ----
module cmh_phy_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       us_bit,
	input  wire logic       us_valid,
	input  wire logic       us_frame_start,
	input  wire logic [7:0] ds_octet,
	input  wire logic       ds_valid
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Receiving side of both line paths
	// ----------------------------------------
	logic [7:0] sh;
	int         nbit;
	int         n_starts;
	logic [7:0] got[$];

	initial begin
		n_starts = 0;
		nbit = 0;
		sh = 8'h00;
	end

	// Bench clears the queue itself before each frame
	always @(posedge clk) begin
		if (!rstn) begin
			nbit = 0;
		end else begin
			if (us_frame_start) begin
				n_starts++;
				nbit = 0;
			end
			if (us_valid) begin
				sh = {us_bit, sh[7:1]};
				nbit++;
				if (nbit == 8) begin
					got.push_back(sh);
					nbit = 0;
				end
			end
			if (ds_valid) begin
				got.push_back(ds_octet);
			end
		end
	end
endmodule

// ---- bench/test_cable_mac_header_framer.sv ----
module test_cable_mac_header_framer;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic [7:0]  fc;
		logic [7:0]  parm;
		logic [15:0] len;
		logic [8:0]  nb;
		logic        path;
		logic        bad;
		logic [1:0]  why;
	} cmh_row_s;

	logic        clk;
	logic        rstn;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        us_bit;
	logic        us_valid;
	logic        us_frame_start;
	logic [7:0]  ds_octet;
	logic        ds_valid;
	int          n_errors;
	int          num_checks;
	int          cycles;
	logic [15:0] header_check_sequence;
	logic [7:0]  exp_q[$];

	// Ordinary cases: fc, parm, len, bytes, path, refused, reason
	cmh_row_s rows [15] = '{
		'{8'h00, 8'h55, 16'h0002, 9'd2, 1'b1, 1'b0, 2'h0}, '{8'h01, 8'h02, 16'h0003, 9'd3, 1'b0, 1'b0, 2'h0},
		'{8'hf8, 8'h03, 16'h0001, 9'd1, 1'b1, 1'b0, 2'h0}, '{8'hc4, 8'h07, 16'h3fff, 9'd0, 1'b0, 1'b0, 2'h0},
		'{8'hc0, 8'h00, 16'h0001, 9'd1, 1'b1, 1'b0, 2'h0}, '{8'hc2, 8'h00, 16'h0001, 9'd1, 1'b0, 1'b0, 2'h0},
		'{8'hc6, 8'h00, 16'h0001, 9'd1, 1'b1, 1'b0, 2'h0}, '{8'h40, 8'h00, 16'h0001, 9'd1, 1'b1, 1'b0, 2'h0},
		'{8'h80, 8'h00, 16'h0001, 9'd1, 1'b0, 1'b0, 2'h0}, '{8'h01, 8'h00, 16'h0000, 9'd0, 1'b1, 1'b0, 2'h0},
		'{8'h01, 8'hf0, 16'h00f0, 9'd240, 1'b1, 1'b0, 2'h0}, '{8'hff, 8'h00, 16'h0000, 9'd0, 1'b1, 1'b1, 2'h0},
		'{8'h01, 8'hf1, 16'h0000, 9'd0, 1'b1, 1'b1, 2'h1}, '{8'h00, 8'h00, 16'h0003, 9'd0, 1'b0, 1'b1, 2'h2},
		'{8'hc4, 8'h00, 16'h4000, 9'd0, 1'b1, 1'b1, 2'h3}};

	cmh_host DUT (
		.clk            (clk),
		.rstn           (rstn),
		.paddr          (paddr),
		.psel           (psel),
		.penable        (penable),
		.pwrite         (pwrite),
		.pwdata         (pwdata),
		.prdata         (prdata),
		.pready         (pready),
		.pslverr        (pslverr),
		.us_bit         (us_bit),
		.us_valid       (us_valid),
		.us_frame_start (us_frame_start),
		.ds_octet       (ds_octet),
		.ds_valid       (ds_valid)
	);

	cmh_phy_model phy (
		.clk            (clk),
		.rstn           (rstn),
		.us_bit         (us_bit),
		.us_valid       (us_valid),
		.us_frame_start (us_frame_start),
		.ds_octet       (ds_octet),
		.ds_valid       (ds_valid)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Longest case is the full buffer frame; this leaves ample margin
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			give_verdict();
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	// Entered just after an edge; one idle edge at the end avoids a double drive
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
			output logic e);
		int t;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (t == 50) begin
			n_errors++;
			$display("MISMATCH pready expected 1 seen 0");
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
		chk("pslverr", {31'h0, ee}, {31'h0, e});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
		chk("rd pslverr", 32'h0, {31'h0, e});
	endtask

	task automatic wait_idle;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 400; i++) begin
			apb(cmh_pkg::OFF_STATUS, 1'b0, 32'h0, r, e);
			if (r[cmh_pkg::STAT_BUSY_BIT] === 1'b0) break;
		end
		chk("busy", 32'h0, {31'h0, r[cmh_pkg::STAT_BUSY_BIT]});
	endtask

	function automatic logic [7:0] pat(input int k);
		return 8'(k * 37 + 5);
	endfunction

	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c;
		for (int j = 7; j >= 0; j--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ b[j]) ? cmh_pkg::HCS_POLY : 16'h0000);
		end
		return r;
	endfunction

	// Expected octets: fixed header, extension, check, payload
	task automatic build(input cmh_row_s rw);
		logic [15:0] c;
		logic [7:0]  b;
		int          x;
		x = rw.fc[0] ? int'(rw.parm) : 0;
		b = (rw.fc[0] || rw.fc == 8'hf8 || rw.fc == 8'hc4) ? rw.parm : 8'h00;
		exp_q = '{rw.fc, b, rw.len[15:8], rw.len[7:0]};
		for (int k = 0; k < x; k++) exp_q.push_back(pat(k));
		c = cmh_pkg::HCS_INIT;
		foreach (exp_q[j]) c = crc8(c, exp_q[j]);
		exp_q.push_back(c[15:8]);
		exp_q.push_back(c[7:0]);
		for (int k = x; k < int'(rw.nb); k++) exp_q.push_back(pat(k));
		header_check_sequence = c;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cmh_row_s    rw;
		logic [31:0] r;
		logic        e;
		int          s0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		num_checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 15; i++) begin
			rw = rows[i];
			for (int k = 0; k < int'(rw.nb); k++) wr(cmh_pkg::OFF_DATA, {24'h0, pat(k)}, 1'b0);
			wr(cmh_pkg::OFF_HDR, {rw.len, rw.parm, rw.fc}, 1'b0);
			phy.got.delete();
			s0 = phy.n_starts;
			wr(cmh_pkg::OFF_CTRL, {30'h0, rw.path, 1'b1}, 1'b0);
			wait_idle();
			rd(cmh_pkg::OFF_STATUS, r);
			chk("refused", {31'h0, rw.bad}, {31'h0, r[1]});
			chk("buffered", 32'h0, {23'h0, r[24:16]});
			if (rw.bad) begin
				chk("reason", {30'h0, rw.why}, {30'h0, r[3:2]});
				chk("octets sent", 32'h0, 32'(phy.got.size()));
				wr(cmh_pkg::OFF_STATUS, 32'h2, 1'b0);
			end else begin
				build(rw);
				chk("frame size", 32'(exp_q.size()), 32'(phy.got.size()));
				foreach (exp_q[j]) chk("octet", {24'h0, exp_q[j]}, {24'h0, phy.got[j]});
				rd(cmh_pkg::OFF_HCS, r);
				chk("hcs reg", {16'h0, header_check_sequence}, {16'h0, r[15:0]});
				chk("frame starts", {31'h0, ~rw.path}, 32'(phy.n_starts - s0));
			end
			$display("test row %0d done", i);
		end
		// Fill until refused, then launch and try to disturb it
		for (int k = 0; k < 256; k++) wr(cmh_pkg::OFF_DATA, {24'h0, pat(k)}, 1'b0);
		wr(cmh_pkg::OFF_DATA, 32'h0, 1'b1);
		rd(cmh_pkg::OFF_STATUS, r);
		chk("buffered", 32'd256, {23'h0, r[24:16]});
		wr(cmh_pkg::OFF_HDR, 32'h0100_0000, 1'b0);
		phy.got.delete();
		wr(cmh_pkg::OFF_CTRL, 32'h3, 1'b0);
		wr(cmh_pkg::OFF_DATA, 32'h0, 1'b1);
		wr(cmh_pkg::OFF_CTRL, 32'h3, 1'b1);
		wr(cmh_pkg::OFF_HDR, 32'h0, 1'b1);
		wait_idle();
		chk("long frame", 32'd262, 32'(phy.got.size()));
		$display("test full buffer done");
		wr(8'h14, 32'h0, 1'b1);
		apb(8'h14, 1'b0, 32'h0, r, e);
		chk("unmapped read", 32'h1, {31'h0, e});
		$display("test unmapped done");
		// Second reset in mid-run
		wr(cmh_pkg::OFF_HDR, 32'h0001_0000, 1'b0);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("idle octet", 32'hff, {24'h0, ds_octet});
		rd(cmh_pkg::OFF_HDR, r);
		chk("hdr reset", 32'h0, r);
		rd(cmh_pkg::OFF_STATUS, r);
		chk("status reset", 32'h0, r);
		$display("test reset done");
		give_verdict();
	end
endmodule
